// ### design/csr_map.svh
// Register indices, field positions, reset values and decode constants.
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH
`define CSR_IDX_TERM       8'h03
`define CSR_IDX_CURR       8'h04
`define CSR_IDX_VTH        8'h05
`define CSR_TERM_SEL_LSB   0
`define CSR_C20_BIT        7
`define CSR_C10_BIT        6
`define CSR_TIED_BIT       5
`define CSR_FAST_LSB       2
`define CSR_PRE_LSB        0
`define CSR_VTH_UNUSED_BIT 7
`define CSR_RCH_LSB        5
`define CSR_DEAD_LSB       3
`define CSR_LOW_LSB        0
`define CSR_TERM_RST       8'h01
`define CSR_CURR_RST       8'h3E
`define CSR_VTH_RST        8'h6B
`define CSR_TERM_MIN       16'h0113
`define CSR_TERM_BASE      16'h0145
`define CSR_TERM_STEP      16'h00C8
`define CSR_FAST_BASE      16'h0226
`define CSR_FAST_STEP      16'h0064
`define CSR_RCH_BASE       16'h0050
`define CSR_RCH_STEP       16'h003C
`define CSR_LOW_BASE       16'h010E
`define CSR_LOW_STEP       16'h000A
`endif

// ### design/csr_pkg.sv
// Types shared by the charge setpoint register bank.
package csr_pkg;
  typedef logic [7:0]  csr_byte_t;
  typedef logic [15:0] csr_val_t;
  typedef enum logic [2:0] {
    CSR_SRC_SEL = 3'b001,
    CSR_SRC_C10 = 3'b010,
    CSR_SRC_C20 = 3'b100
  } csr_term_src_t;
endpackage

// ### design/csr_decode.sv
// Combinational decode of the coded setpoint fields into physical values.
`timescale 1ns/10ps
`include "csr_map.svh"
module csr_decode
  import csr_pkg::*;
(
  input  wire csr_pkg::csr_byte_t     term_reg_in,
  input  wire csr_pkg::csr_byte_t     curr_reg_in,
  input  wire csr_pkg::csr_byte_t     vth_reg_in,
  input  wire logic [15:0]            batt_capacity_in,
  output csr_pkg::csr_val_t           term_current_out,
  output csr_pkg::csr_term_src_t      term_src_out,
  output csr_pkg::csr_val_t           fast_current_out,
  output csr_pkg::csr_val_t           precharge_current_out,
  output csr_pkg::csr_val_t           recharge_hyst_out,
  output csr_pkg::csr_val_t           dead_batt_thresh_out,
  output csr_pkg::csr_val_t           low_batt_thresh_out
);
  import csr_pkg::*;

  // Linear code-to-value map: base plus code times step.
  function automatic csr_val_t lin(input logic [2:0] code, input csr_val_t base,
                                   input csr_val_t step);
    lin = 16'(base + 16'(code) * step);
  endfunction

  // Lower clamp of a capacity-derived termination current.
  function automatic csr_val_t floor_term(input csr_val_t val);
    floor_term = (val < `CSR_TERM_MIN) ? `CSR_TERM_MIN : val;
  endfunction

  logic [1:0] term_current_sel;
  logic [2:0] fast_current_sel;
  logic [1:0] precharge_current_sel;
  logic [1:0] recharge_hyst_sel;
  logic [1:0] dead_batt_thresh_sel;
  logic [2:0] low_batt_thresh_sel;

  always_comb begin
    term_current_sel      = term_reg_in[`CSR_TERM_SEL_LSB +: 2];
    fast_current_sel      = curr_reg_in[`CSR_FAST_LSB +: 3];
    precharge_current_sel = curr_reg_in[`CSR_PRE_LSB +: 2];
    recharge_hyst_sel     = vth_reg_in[`CSR_RCH_LSB +: 2];
    dead_batt_thresh_sel  = vth_reg_in[`CSR_DEAD_LSB +: 2];
    low_batt_thresh_sel   = vth_reg_in[`CSR_LOW_LSB +: 3];
    // Termination current is in 0.1 mA units; capacity is in mAh.
    if (curr_reg_in[`CSR_C20_BIT]) begin
      term_current_out = floor_term({1'b0, batt_capacity_in[15:1]});
      term_src_out     = CSR_SRC_C20;
    end else if (curr_reg_in[`CSR_C10_BIT]) begin
      term_current_out = floor_term(batt_capacity_in);
      term_src_out     = CSR_SRC_C10;
    end else begin
      term_current_out = lin({1'b0, term_current_sel}, `CSR_TERM_BASE,
                             `CSR_TERM_STEP);
      term_src_out     = CSR_SRC_SEL;
    end
    fast_current_out = lin(fast_current_sel, `CSR_FAST_BASE, `CSR_FAST_STEP);
    case (precharge_current_sel)
      2'h0:    precharge_current_out = 16'h0005;
      2'h1:    precharge_current_out = 16'h000A;
      default: precharge_current_out = 16'h0014;
    endcase
    recharge_hyst_out = lin({1'b0, recharge_hyst_sel}, `CSR_RCH_BASE,
                            `CSR_RCH_STEP);
    case (dead_batt_thresh_sel)
      2'h0:    dead_batt_thresh_out = 16'h00F0;
      2'h1:    dead_batt_thresh_out = 16'h00FA;
      2'h2:    dead_batt_thresh_out = 16'h0104;
      default: dead_batt_thresh_out = 16'h014A;
    endcase
    low_batt_thresh_out = lin(low_batt_thresh_sel, `CSR_LOW_BASE, `CSR_LOW_STEP);
  end
endmodule // csr_decode

// ### design/csr_regs.sv
// APB register bank holding the charger setpoints and their decoded values.
//
// Overview of operation
// - The two-bit termination selector maps 00..11 to 32.5/52.5/72.5/92.5 mA, reset 01.
// - With the capacity/20 bit (bit 7) set, termination is capacity/20, floored at 27.5 mA.
// - With bit 6 set and bit 7 clear termination is capacity/10, else the selector applies.
// - The fast charge field in bits 4..2 selects 550 mA plus 100 mA per code, reset 111.
// - The precharge field in bits 1..0 maps to 5, 10, 20, 20 mA and resets to 10.
// - The recharge field in bits 6..5 maps to 80, 140, 200, 260 mV and resets to 11.
// - The dead battery field in bits 4..3 maps to 2.4, 2.5, 2.6, 3.3 V and resets to 01.
// - The low battery field in bits 2..0 selects 2.7 V plus 0.1 V per code, reset 011.
`timescale 1ns/10ps
`include "csr_map.svh"
module csr_regs
  import csr_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   ce_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [ADDR_W-1:0]      paddr_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [3:0]             pstrb_in,
  input  wire logic [15:0]            batt_capacity_in,
  output logic [31:0]                 prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  output csr_pkg::csr_byte_t          term_cfg_out,
  output csr_pkg::csr_byte_t          curr_cfg_out,
  output csr_pkg::csr_byte_t          vth_cfg_out,
  output csr_pkg::csr_val_t           term_current_out,
  output csr_pkg::csr_term_src_t      term_src_out,
  output csr_pkg::csr_val_t           fast_current_out,
  output csr_pkg::csr_val_t           precharge_current_out,
  output csr_pkg::csr_val_t           recharge_hyst_out,
  output csr_pkg::csr_val_t           dead_batt_thresh_out,
  output csr_pkg::csr_val_t           low_batt_thresh_out
);
  import csr_pkg::*;

  // Byte address of a register index.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = ADDR_W'({idx, 2'b00});
  endfunction

  // Forces the fixed bits of a stored register image.
  function automatic csr_byte_t fix_bits(input logic [1:0] which, input csr_byte_t v);
    csr_byte_t r;
    r = v;
    if (which == 2'h1) begin
      r[`CSR_TIED_BIT] = 1'b1;
    end else if (which == 2'h2) begin
      r[`CSR_VTH_UNUSED_BIT] = 1'b0;
    end
    fix_bits = r;
  endfunction

  csr_byte_t     term_q, term_d;
  csr_byte_t     curr_q, curr_d;
  csr_byte_t     vth_q, vth_d;
  logic [31:0]   rdata_q, rdata_d;
  logic          ready_q, ready_d;
  logic          err_q, err_d;
  csr_val_t      term_cur_q, fast_q, pre_q, rch_q, dead_q, low_q;
  csr_term_src_t src_q;
  csr_val_t      term_cur_c, fast_c, pre_c, rch_c, dead_c, low_c;
  csr_term_src_t src_c;
  logic          hit_term, hit_curr, hit_vth, mapped;
  logic          wr_commit;

  csr_decode u_decode (
    .term_reg_in           (term_q),
    .curr_reg_in           (curr_q),
    .vth_reg_in            (vth_q),
    .batt_capacity_in      (batt_capacity_in),
    .term_current_out      (term_cur_c),
    .term_src_out          (src_c),
    .fast_current_out      (fast_c),
    .precharge_current_out (pre_c),
    .recharge_hyst_out     (rch_c),
    .dead_batt_thresh_out  (dead_c),
    .low_batt_thresh_out   (low_c)
  );

  // Bus front end: answer one cycle after setup, so pready is a flop.
  always_comb begin
    hit_term  = (paddr_in == reg_addr(`CSR_IDX_TERM));
    hit_curr  = (paddr_in == reg_addr(`CSR_IDX_CURR));
    hit_vth   = (paddr_in == reg_addr(`CSR_IDX_VTH));
    mapped    = hit_term | hit_curr | hit_vth;
    wr_commit = psel_in & penable_in & ready_q & pwrite_in & mapped & ~err_q
                & pstrb_in[0];
    ready_d   = psel_in & ~penable_in;
    // The error flag stands only in the answer cycle, so it can drive pslverr directly.
    err_d     = 1'b0;
    rdata_d   = rdata_q;
    if (psel_in & ~penable_in) begin
      err_d   = ~mapped;
      rdata_d = 32'h0000_0000;
      if (~pwrite_in) begin
        if (hit_term) begin
          rdata_d = {24'h00_0000, term_q};
        end else if (hit_curr) begin
          rdata_d = {24'h00_0000, curr_q};
        end else if (hit_vth) begin
          rdata_d = {24'h00_0000, vth_q};
        end
      end
    end
  end

  // Register image next state; only the low byte lane carries data.
  always_comb begin
    term_d = term_q;
    curr_d = curr_q;
    vth_d  = vth_q;
    if (wr_commit & hit_term) begin
      term_d = {6'h00, pwdata_in[`CSR_TERM_SEL_LSB +: 2]};
    end
    if (wr_commit & hit_curr) begin
      curr_d = fix_bits(2'h1, pwdata_in[7:0]);
    end
    if (wr_commit & hit_vth) begin
      vth_d = fix_bits(2'h2, pwdata_in[7:0]);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      term_q     <= `CSR_TERM_RST;
      curr_q     <= `CSR_CURR_RST;
      vth_q      <= `CSR_VTH_RST;
      rdata_q    <= 32'h0000_0000;
      ready_q    <= 1'b0;
      err_q      <= 1'b0;
      term_cur_q <= 16'h0000;
      src_q      <= CSR_SRC_SEL;
      fast_q     <= 16'h0000;
      pre_q      <= 16'h0000;
      rch_q      <= 16'h0000;
      dead_q     <= 16'h0000;
      low_q      <= 16'h0000;
    end else if (ce_in) begin
      term_q     <= term_d;
      curr_q     <= curr_d;
      vth_q      <= vth_d;
      rdata_q    <= rdata_d;
      ready_q    <= ready_d;
      err_q      <= err_d;
      term_cur_q <= term_cur_c;
      src_q      <= src_c;
      fast_q     <= fast_c;
      pre_q      <= pre_c;
      rch_q      <= rch_c;
      dead_q     <= dead_c;
      low_q      <= low_c;
    end
  end

  always_comb begin
    prdata_out            = rdata_q;
    pready_out            = ready_q;
    pslverr_out           = err_q;
    term_cfg_out          = term_q;
    curr_cfg_out          = curr_q;
    vth_cfg_out           = vth_q;
    term_current_out      = term_cur_q;
    term_src_out          = src_q;
    fast_current_out      = fast_q;
    precharge_current_out = pre_q;
    recharge_hyst_out     = rch_q;
    dead_batt_thresh_out  = dead_q;
    low_batt_thresh_out   = low_q;
  end
endmodule // csr_regs

// ### tb/csr_regs_props.sv
// Port assertions for the charge setpoint register bank.
`timescale 1ns/10ps
module csr_regs_props
  import csr_pkg::*;
(
  input wire logic                   clk_in,
  input wire logic                   sys_rst_in,
  input wire logic                   ce_in,
  input wire logic                   psel_in,
  input wire logic                   penable_in,
  input wire logic [15:0]            batt_capacity_in,
  input wire logic                   pready_out,
  input wire logic                   pslverr_out,
  input wire csr_pkg::csr_byte_t     term_cfg_out,
  input wire csr_pkg::csr_byte_t     curr_cfg_out,
  input wire csr_pkg::csr_byte_t     vth_cfg_out,
  input wire csr_pkg::csr_val_t      term_current_out,
  input wire csr_pkg::csr_term_src_t term_src_out,
  input wire csr_pkg::csr_val_t      fast_current_out,
  input wire csr_pkg::csr_val_t      precharge_current_out,
  input wire csr_pkg::csr_val_t      recharge_hyst_out,
  input wire csr_pkg::csr_val_t      dead_batt_thresh_out,
  input wire csr_pkg::csr_val_t      low_batt_thresh_out
);
  import csr_pkg::*;
  function automatic csr_val_t t_exp(csr_byte_t t, csr_byte_t c, logic [15:0] p);
    logic [15:0] v;
    v = c[7] ? (p >> 1) : p;
    if (!c[7] && !c[6]) return 16'h0145 + 16'h00C8 * t[1:0];
    return (v < 16'h0113) ? 16'h0113 : v;
  endfunction
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !ce_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  // Decoded outputs follow their inputs one enabled clock later.
  property p_lag(csr_val_t v, csr_val_t e);
    !$past(sys_rst_in) && $past(ce_in) |-> v == e;
  endproperty
  a_ready_after_setup: assert property (s_setup |=> pready_out)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready held");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_term_value: assert property (p_lag(term_current_out, t_exp($past(term_cfg_out),
    $past(curr_cfg_out), $past(batt_capacity_in)))) else $error("termination value");
  a_term_source: assert property (p_lag(term_src_out, $past(curr_cfg_out[7]) ? 3'h4 :
    ($past(curr_cfg_out[6]) ? 3'h2 : 3'h1))) else $error("termination source");
  a_fast_decode: assert property (p_lag(fast_current_out,
    16'h0226 + 16'h0064 * $past(curr_cfg_out[4:2]))) else $error("fast current");
  a_pre_decode: assert property (p_lag(precharge_current_out,
    $past(curr_cfg_out[1]) ? 16'h0014 : ($past(curr_cfg_out[0]) ? 16'h000A : 16'h0005)))
    else $error("precharge current");
  a_rch_decode: assert property (p_lag(recharge_hyst_out,
    16'h0050 + 16'h003C * $past(vth_cfg_out[6:5]))) else $error("recharge threshold");
  a_dead_decode: assert property (p_lag(dead_batt_thresh_out, (&$past(vth_cfg_out[4:3])) ?
    16'h014A : 16'h00F0 + 16'h000A * $past(vth_cfg_out[4:3]))) else $error("dead threshold");
  a_low_decode: assert property (p_lag(low_batt_thresh_out,
    16'h010E + 16'h000A * $past(vth_cfg_out[2:0]))) else $error("low threshold");
  a_fixed_bits: assert property (curr_cfg_out[5] && !vth_cfg_out[7] && !(|term_cfg_out[7:2]))
    else $error("fixed bits wrong");
endmodule // csr_regs_props
bind csr_regs csr_regs_props i_props (
  .clk_in                (clk_in),
  .sys_rst_in            (sys_rst_in),
  .ce_in                 (ce_in),
  .psel_in               (psel_in),
  .penable_in            (penable_in),
  .batt_capacity_in      (batt_capacity_in),
  .pready_out            (pready_out),
  .pslverr_out           (pslverr_out),
  .term_cfg_out          (term_cfg_out),
  .curr_cfg_out          (curr_cfg_out),
  .vth_cfg_out           (vth_cfg_out),
  .term_current_out      (term_current_out),
  .term_src_out          (term_src_out),
  .fast_current_out      (fast_current_out),
  .precharge_current_out (precharge_current_out),
  .recharge_hyst_out     (recharge_hyst_out),
  .dead_batt_thresh_out  (dead_batt_thresh_out),
  .low_batt_thresh_out   (low_batt_thresh_out)
);

// ### tb/test_charge_setpoint_registers.sv
// Self-checking bench for the charge setpoint register bank.
`timescale 1ns/10ps
module test_charge_setpoint_registers;
  import csr_pkg::*;
  logic          clk_in = 1'b0;
  logic          sys_rst_in = 1'b1;
  logic          ce_in = 1'b1;
  logic          psel_in = 1'b0;
  logic          penable_in = 1'b0;
  logic          pwrite_in = 1'b0;
  logic [11:0]   paddr_in = 12'h000;
  logic [31:0]   pwdata_in = 32'h0;
  logic [3:0]    pstrb_in = 4'hF;
  logic [15:0]   batt_capacity_in = 16'h03E8;
  logic [31:0]   prdata_out, rd;
  logic          pready_out, pslverr_out, er, w;
  csr_byte_t     term_cfg_out, curr_cfg_out, vth_cfg_out, d, x;
  csr_val_t      term_current_out, fast_current_out, precharge_current_out;
  csr_val_t      recharge_hyst_out, dead_batt_thresh_out, low_batt_thresh_out;
  csr_term_src_t term_src_out;
  logic [11:0]   a;
  logic [28:0]   rows [8] = '{{13'h000C, 16'h0001}, {13'h0010, 16'h003E}, {13'h0014, 16'h006B},
    {13'h100C, 16'hFF03}, {13'h1010, 16'hDFFF}, {13'h1010, 16'h0020}, {13'h1014, 16'hFF7F},
    {13'h1014, 16'h0000}};
  logic [42:0]   pri [4] = '{{8'h60, 16'h03E8, 16'h03E8, 3'h2}, {8'hE0, 16'h03E8, 16'h01F4, 3'h4},
    {8'hE0, 16'h0190, 16'h0113, 3'h4}, {8'h60, 16'h00C8, 16'h0113, 3'h2}};
  int            fail_count = 0;
  int            checked = 0;
  int            cyc = 0;
  csr_regs i_dut (
    .clk_in                (clk_in),
    .sys_rst_in            (sys_rst_in),
    .ce_in                 (ce_in),
    .psel_in               (psel_in),
    .penable_in            (penable_in),
    .pwrite_in             (pwrite_in),
    .paddr_in              (paddr_in),
    .pwdata_in             (pwdata_in),
    .pstrb_in              (pstrb_in),
    .batt_capacity_in      (batt_capacity_in),
    .prdata_out            (prdata_out),
    .pready_out            (pready_out),
    .pslverr_out           (pslverr_out),
    .term_cfg_out          (term_cfg_out),
    .curr_cfg_out          (curr_cfg_out),
    .vth_cfg_out           (vth_cfg_out),
    .term_current_out      (term_current_out),
    .term_src_out          (term_src_out),
    .fast_current_out      (fast_current_out),
    .precharge_current_out (precharge_current_out),
    .recharge_hyst_out     (recharge_hyst_out),
    .dead_batt_thresh_out  (dead_batt_thresh_out),
    .low_batt_thresh_out   (low_batt_thresh_out)
  );
  always #5 clk_in = ~clk_in;
  task automatic end_sim;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [7:0] wd);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= ad;
    pwdata_in <= {24'h0, wd};
    @(posedge clk_in);
    penable_in <= 1'b1;
    // The wait ends when pready_out is seen high; the bench timeout ends it only if pready_out never rises.
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    cmp(term_current_out, 32'h20D);
    cmp(term_src_out, 32'h1);
    cmp(fast_current_out, 32'h4E2);
    cmp(precharge_current_out, 32'h14);
    cmp(recharge_hyst_out, 32'h104);
    cmp(dead_batt_thresh_out, 32'hFA);
    cmp(low_batt_thresh_out, 32'h12C);
    for (int i = 0; i < 8; i++) begin
      {w, a, d, x} = rows[i];
      if (w) apb(1'b1, a, d);
      apb(1'b0, a, 8'h00);
      cmp(rd, {24'h0, x});
    end
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h010, {3'h1, k[2:0], k[1:0]});
      apb(1'b1, 12'h014, {1'b0, k[1:0], k[1:0], k[2:0]});
      apb(1'b1, 12'h00C, {6'h00, k[1:0]});
      repeat (2) @(posedge clk_in);
      cmp(term_current_out, 325 + 200 * k[1:0]);
      cmp(fast_current_out, 550 + 100 * k);
      cmp(precharge_current_out, k[1] ? 20 : (k[0] ? 10 : 5));
      cmp(recharge_hyst_out, 80 + 60 * k[1:0]);
      cmp(dead_batt_thresh_out, (k[1:0] == 2'h3) ? 330 : 240 + 10 * k[1:0]);
      cmp(low_batt_thresh_out, 270 + 10 * k);
    end
    for (int i = 0; i < 4; i++) begin
      batt_capacity_in <= pri[i][34:19];
      apb(1'b1, 12'h010, pri[i][42:35]);
      repeat (2) @(posedge clk_in);
      cmp(term_current_out, pri[i][18:3]);
      cmp(term_src_out, pri[i][2:0]);
    end
    // With the clock enable low the decoded outputs must not follow the capacity.
    ce_in <= 1'b0;
    batt_capacity_in <= 16'h07D0;
    repeat (3) @(posedge clk_in);
    cmp(term_current_out, 32'h113);
    ce_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    cmp(term_current_out, 32'h7D0);
    pstrb_in <= 4'hE;
    apb(1'b1, 12'h00C, 8'h00);
    pstrb_in <= 4'hF;
    apb(1'b0, 12'h00C, 8'h00);
    cmp(rd, 32'h3);
    apb(1'b0, 12'h018, 8'h00);
    cmp(rd, 32'h0);
    cmp({31'h0, er}, 32'h1);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, 12'h010, 8'h00);
    cmp(rd, 32'h3E);
    end_sim();
  end
endmodule // test_charge_setpoint_registers
